/* design/link_regs_pkg.sv */
// Summary of operation
// - The low six bits of the mode register pick the serial output mode of the link.
// - In 64b/66b modes K is 256*E/F, and the multiframe register is used only when F is zero.
// - Writing zero to the software sync bit requests sync; it resets to one.
// - A low selected sync pin keeps the request asserted until the pin rises or another source is chosen.
// - The link control register resets to three.
// - With link enable low, link logic and multiframe counter are reset and serializers off.
// - Sync source zero is the dedicated pin, one the timestamp pins, two no pin.
package link_regs_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_LINK_ENABLE = 12'h200;
  localparam logic [11:0] OFS_LINK_OUTPUT_MODE = 12'h201;
  localparam logic [11:0] OFS_FRAMES_PER_MULTIFRAME_MINUS_ONE = 12'h202;
  localparam logic [11:0] OFS_SOFTWARE_SYNC_REQUEST = 12'h203;
  localparam logic [11:0] OFS_LINK_CONTROL = 12'h204;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_LINK_ENABLE = 8'h01;
  localparam logic [7:0] RST_LINK_OUTPUT_MODE = 8'h00;
  localparam logic [7:0] RST_FRAMES_PER_MULTIFRAME_MINUS_ONE = 8'h1F;
  localparam logic [7:0] RST_SOFTWARE_SYNC_REQUEST = 8'h01;
  localparam logic [7:0] RST_LINK_CONTROL = 8'h03;
  localparam logic [15:0] RST_FRAMES_PER_MULTIFRAME = 16'h0020;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LINK_ENABLE_BIT = 0;
  localparam int MODE_MSB = 5;
  localparam int SW_SYNC_BIT = 0;
  localparam int SCRAMBLE_BIT = 0;
  localparam int SAMPLE_FORMAT_BIT = 1;
  localparam int SYNC_SELECT_LSB = 2;
  localparam int SYNC_SELECT_MSB = 3;
  localparam int ALT_LANES_BIT = 4;

  // ****************************************************************
  // sync source encodings and K derivation
  // ****************************************************************
  typedef enum logic [1:0] {
    SYNC_SRC_DEDICATED_PIN = 2'h0,
    SYNC_SRC_TIMESTAMP_PINS = 2'h1,
    SYNC_SRC_NONE = 2'h2,
    SYNC_SRC_RESERVED = 2'h3
  } sync_source_e;

  localparam logic [15:0] K_SCALE_64B66B = 16'h0100;

endpackage : link_regs_pkg

/* design/serial_link_mode_sync_regs.sv */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module serial_link_mode_sync_regs #(
  parameter int ADDR_WIDTH = 12,
  parameter int EF_WIDTH = 8
)
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [ADDR_WIDTH-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [7:0] REG_RDATA,
  input wire logic CALIBRATION_ENABLE,
  input wire logic MODE_IS_64B66B,
  input wire logic [EF_WIDTH-1:0] MODE_E,
  input wire logic [EF_WIDTH-1:0] MODE_F,
  input wire logic DEDICATED_SYNC_INPUT_PIN_N,
  input wire logic TIMESTAMP_INPUT_PINS_N,
  output logic [5:0] LINK_OUTPUT_MODE,
  output logic [15:0] FRAMES_PER_MULTIFRAME,
  output logic SYNC_REQUEST_N,
  output logic SCRAMBLE_ENABLE,
  output logic SAMPLE_FORMAT_SIGNED,
  output logic ALT_LANES,
  output logic LINK_RESET,
  output logic MULTIFRAME_COUNTER_RESET,
  output logic SERIALIZER_POWER_DOWN,
  output logic LINK_CLOCK_ENABLE,
  output logic MODE_WRITE_REFUSED
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial
  begin
    // offsets reach 0x204, so ten bits at the least
    if (ADDR_WIDTH < 10)
    begin
      $error("ADDR_WIDTH too small for the register offsets");
    end
    // a wider bus would alias onto the twelve-bit decode
    if (ADDR_WIDTH > 12)
    begin
      $error("ADDR_WIDTH too large for the exact decode");
    end
    // 256*E must stay inside sixteen bits
    if (EF_WIDTH < 1 || EF_WIDTH > 8)
    begin
      $error("EF_WIDTH must lie between 1 and 8");
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] link_enable;
    logic [7:0] output_mode;
    logic [7:0] k_minus_one;
    logic [7:0] sw_sync;
    logic [7:0] link_control;
    logic [7:0] rdata;
    logic sync_req_n;
    logic [15:0] frames_k;
    logic mode_refused;
  } state_s;

  // registered state and its next value
  state_s st_q;
  state_s st_d;

  // decoded address
  logic [11:0] addr;
  // level of the chosen sync pin, low asks for sync
  logic pin_level_n;
  // K worked out from the mode's E and F
  logic [15:0] k_from_ef;
  logic [15:0] scaled_e;
  // sync source field of the link control register
  logic [1:0] sync_sel;

  // address to package width
  assign addr = 12'(REG_ADDR);
  assign sync_sel = st_q.link_control[link_regs_pkg::SYNC_SELECT_MSB:link_regs_pkg::SYNC_SELECT_LSB];

  // sync pin chosen by the source field
  // code three is reserved and, like two, leaves only the software bit
  always_comb
  begin
    unique case (sync_sel)
      link_regs_pkg::SYNC_SRC_DEDICATED_PIN: pin_level_n = DEDICATED_SYNC_INPUT_PIN_N;
      link_regs_pkg::SYNC_SRC_TIMESTAMP_PINS: pin_level_n = TIMESTAMP_INPUT_PINS_N;
      link_regs_pkg::SYNC_SRC_NONE: pin_level_n = 1'b1;
      default: pin_level_n = 1'b1;
    endcase
  end

  // effective K from E and F in 64b/66b modes
  always_comb
  begin
    // at most 256*255, inside sixteen bits
    scaled_e = link_regs_pkg::K_SCALE_64B66B * 16'(MODE_E);
    // F of zero would divide by zero: fall back to the register
    if (MODE_F == '0)
    begin
      k_from_ef = 16'(st_q.k_minus_one) + 16'h0001;
    end
    else
    begin
      k_from_ef = scaled_e / 16'(MODE_F);
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    // hold every field but read data and the refusal flag unless a strobe or an input moves it
    st_d = st_q;
    st_d.mode_refused = 1'b0;
    // register writes, unmapped offsets ignored
    if (REG_WRITE)
    begin
      unique case (addr)
        link_regs_pkg::OFS_LINK_ENABLE: st_d.link_enable = REG_WDATA;
        link_regs_pkg::OFS_LINK_OUTPUT_MODE:
        begin
          st_d.output_mode = REG_WDATA;
          // flag a mode change made while the link is live or calibration is enabled
          st_d.mode_refused = st_q.link_enable[link_regs_pkg::LINK_ENABLE_BIT]
            | CALIBRATION_ENABLE;
        end
        link_regs_pkg::OFS_FRAMES_PER_MULTIFRAME_MINUS_ONE: st_d.k_minus_one = REG_WDATA;
        link_regs_pkg::OFS_SOFTWARE_SYNC_REQUEST: st_d.sw_sync = REG_WDATA;
        link_regs_pkg::OFS_LINK_CONTROL: st_d.link_control = REG_WDATA;
        default: st_d.rdata = st_q.rdata;
      endcase
    end

    // read data valid only in the cycle after the strobe
    st_d.rdata = 8'h00;
    if (REG_READ)
    begin
      unique case (addr)
        link_regs_pkg::OFS_LINK_ENABLE: st_d.rdata = st_q.link_enable;
        link_regs_pkg::OFS_LINK_OUTPUT_MODE: st_d.rdata = st_q.output_mode;
        link_regs_pkg::OFS_FRAMES_PER_MULTIFRAME_MINUS_ONE: st_d.rdata = st_q.k_minus_one;
        link_regs_pkg::OFS_SOFTWARE_SYNC_REQUEST: st_d.rdata = st_q.sw_sync;
        link_regs_pkg::OFS_LINK_CONTROL: st_d.rdata = st_q.link_control;
        default: st_d.rdata = 8'h00;
      endcase
    end

    // software bit and selected pin, low on either requests sync
    st_d.sync_req_n = st_q.sw_sync[link_regs_pkg::SW_SYNC_BIT] & pin_level_n;

    // effective frames per multiframe
    if (MODE_IS_64B66B)
    begin
      st_d.frames_k = k_from_ef;
    end
    else
    begin
      st_d.frames_k = 16'(st_q.k_minus_one) + 16'h0001;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN)
  begin
    // every field to its reset value, one edge is enough
    if (!RESETN)
    begin
      st_q.link_enable <= link_regs_pkg::RST_LINK_ENABLE;
      st_q.output_mode <= link_regs_pkg::RST_LINK_OUTPUT_MODE;
      st_q.k_minus_one <= link_regs_pkg::RST_FRAMES_PER_MULTIFRAME_MINUS_ONE;
      st_q.sw_sync <= link_regs_pkg::RST_SOFTWARE_SYNC_REQUEST;
      st_q.link_control <= link_regs_pkg::RST_LINK_CONTROL;
      st_q.rdata <= 8'h00;
      st_q.sync_req_n <= 1'b1;
      st_q.frames_k <= link_regs_pkg::RST_FRAMES_PER_MULTIFRAME;
      st_q.mode_refused <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // read data, zero outside the cycle after a read
  assign REG_RDATA = st_q.rdata;

  // mode field, reserved top bits stored but not driven
  assign LINK_OUTPUT_MODE = st_q.output_mode[link_regs_pkg::MODE_MSB:0];

  // effective K and sync request, one cycle behind their inputs
  assign FRAMES_PER_MULTIFRAME = st_q.frames_k;
  assign SYNC_REQUEST_N = st_q.sync_req_n;

  // link control bits
  assign SCRAMBLE_ENABLE = st_q.link_control[link_regs_pkg::SCRAMBLE_BIT];
  assign SAMPLE_FORMAT_SIGNED = st_q.link_control[link_regs_pkg::SAMPLE_FORMAT_BIT];
  assign ALT_LANES = st_q.link_control[link_regs_pkg::ALT_LANES_BIT];

  // pulse after a mode write made while the link was live or calibration was enabled
  assign MODE_WRITE_REFUSED = st_q.mode_refused;

  // link held off while disabled
  assign LINK_RESET = ~st_q.link_enable[link_regs_pkg::LINK_ENABLE_BIT];
  assign MULTIFRAME_COUNTER_RESET = ~st_q.link_enable[link_regs_pkg::LINK_ENABLE_BIT];
  assign SERIALIZER_POWER_DOWN = ~st_q.link_enable[link_regs_pkg::LINK_ENABLE_BIT];
  assign LINK_CLOCK_ENABLE = st_q.link_enable[link_regs_pkg::LINK_ENABLE_BIT];

endmodule : serial_link_mode_sync_regs

/* tb/serial_link_mode_sync_regs_asserts.sv */
`timescale 1ns/1ps
module link_regs_asserts (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [7:0] REG_RDATA,
  input wire logic CALIBRATION_ENABLE,
  input wire logic MODE_IS_64B66B,
  input wire logic [7:0] MODE_E,
  input wire logic [7:0] MODE_F,
  input wire logic [5:0] LINK_OUTPUT_MODE,
  input wire logic [15:0] FRAMES_PER_MULTIFRAME,
  input wire logic SYNC_REQUEST_N,
  input wire logic LINK_RESET,
  input wire logic MULTIFRAME_COUNTER_RESET,
  input wire logic SERIALIZER_POWER_DOWN,
  input wire logic LINK_CLOCK_ENABLE,
  input wire logic MODE_WRITE_REFUSED
);
  // ***
  // checks
  // ***
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_sw0;
    REG_WRITE && REG_ADDR == 12'h203 && !REG_WDATA[0];
  endsequence
  sequence s_kw;
    REG_WRITE && REG_ADDR == 12'h202 && !MODE_IS_64B66B ##1 !MODE_IS_64B66B;
  endsequence
  a_rdata_idle: assert property (!$past(REG_READ) |-> REG_RDATA == 8'h00)
    else $error("read data not idle");
  a_sw_sync: assert property (s_sw0 |-> ##2 !SYNC_REQUEST_N)
    else $error("software sync missed");
  a_mode_follows: assert property (REG_WRITE && REG_ADDR == 12'h201 |=>
    LINK_OUTPUT_MODE == 6'($past(REG_WDATA))) else $error("mode field wrong");
  a_k_plain: assert property (s_kw |=>
    FRAMES_PER_MULTIFRAME == 16'($past(REG_WDATA, 2)) + 16'h0001) else $error("k wrong");
  a_k_derived: assert property (MODE_IS_64B66B && MODE_F != 8'h00 |=>
    FRAMES_PER_MULTIFRAME == 16'((32'h100 * $past(MODE_E)) / $past(MODE_F)))
    else $error("derived k wrong");
  a_en_tie: assert property (REG_WRITE && REG_ADDR == 12'h200 |=>
    {LINK_RESET, MULTIFRAME_COUNTER_RESET, SERIALIZER_POWER_DOWN} == {3{!$past(REG_WDATA[0])}})
    else $error("link hold wrong");
  a_en_write: assert property (REG_WRITE && REG_ADDR == 12'h200 |=>
    LINK_CLOCK_ENABLE == 1'($past(REG_WDATA))) else $error("link enable wrong");
  a_mode_flag: assert property (REG_WRITE && REG_ADDR == 12'h201 |=>
    MODE_WRITE_REFUSED == ($past(CALIBRATION_ENABLE) || $past(LINK_CLOCK_ENABLE)))
    else $error("mode flag wrong");
endmodule : link_regs_asserts
bind serial_link_mode_sync_regs link_regs_asserts u_chk (
  .CLK(CLK),
  .RESETN(RESETN),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_WRITE(REG_WRITE),
  .REG_READ(REG_READ),
  .REG_RDATA(REG_RDATA),
  .CALIBRATION_ENABLE(CALIBRATION_ENABLE),
  .MODE_IS_64B66B(MODE_IS_64B66B),
  .MODE_E(MODE_E),
  .MODE_F(MODE_F),
  .LINK_OUTPUT_MODE(LINK_OUTPUT_MODE),
  .FRAMES_PER_MULTIFRAME(FRAMES_PER_MULTIFRAME),
  .SYNC_REQUEST_N(SYNC_REQUEST_N),
  .LINK_RESET(LINK_RESET),
  .MULTIFRAME_COUNTER_RESET(MULTIFRAME_COUNTER_RESET),
  .SERIALIZER_POWER_DOWN(SERIALIZER_POWER_DOWN),
  .LINK_CLOCK_ENABLE(LINK_CLOCK_ENABLE),
  .MODE_WRITE_REFUSED(MODE_WRITE_REFUSED)
);

/* tb/sync_pin_model.sv */
`timescale 1ns/1ps
module sync_pin_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic want_ded,
  input wire logic want_ts,
  output logic ded_n,
  output logic ts_n
);
  // receiver holds its sync pins low while it wants sync
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) {ded_n, ts_n} <= 2'h3;
    else {ded_n, ts_n} <= {!want_ded, !want_ts};
  end
endmodule : sync_pin_model

/* tb/serial_link_mode_sync_regs_tb_top.sv */
`timescale 1ns/1ps
module serial_link_mode_sync_regs_tb_top;
  logic CLK = 0, RESETN = 0, REG_WRITE = 0, REG_READ = 0, CALIBRATION_ENABLE = 0;
  logic MODE_IS_64B66B = 0, w_ded = 0, w_ts = 0, DEDICATED_SYNC_INPUT_PIN_N, TIMESTAMP_INPUT_PINS_N;
  logic [11:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0, MODE_E = 0, MODE_F = 0, REG_RDATA;
  logic [5:0] LINK_OUTPUT_MODE;
  logic [15:0] FRAMES_PER_MULTIFRAME;
  logic SYNC_REQUEST_N, SCRAMBLE_ENABLE, SAMPLE_FORMAT_SIGNED, ALT_LANES, LINK_RESET;
  logic MULTIFRAME_COUNTER_RESET, SERIALIZER_POWER_DOWN, LINK_CLOCK_ENABLE, MODE_WRITE_REFUSED;
  int failures = 0, check_count = 0, cyc = 0;
  logic [7:0] rv [6] = '{8'h01, 8'h00, 8'h1F, 8'h01, 8'h03, 8'h00};
  logic [1:0] sel [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic pd [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic pt [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic ex [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  serial_link_mode_sync_regs u_dut (.*);
  sync_pin_model u_far (.clk(CLK), .rst_n(RESETN), .want_ded(w_ded), .want_ts(w_ts),
    .ded_n(DEDICATED_SYNC_INPUT_PIN_N), .ts_n(TIMESTAMP_INPUT_PINS_N));
  // clock and hang guard
  initial forever #5 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      print_verdict();
    end
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WRITE <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WRITE <= 0;
  endtask : wreg
  task rreg(input logic [11:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_READ <= 1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_READ <= 0;
    #1 chk("rdata", 16'(e), 16'(REG_RDATA));
  endtask : rreg
  task settle;
    repeat (3) @(posedge CLK);
    #1;
  endtask : settle
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    repeat (2) @(posedge CLK);
    RESETN <= 1;
    for (int i = 0; i < 6; i++) rreg(12'(12'h200 + i), rv[i]);
    chk("k", 16'h0020, FRAMES_PER_MULTIFRAME);
    chk("ctl", 16'h0003, 16'({ALT_LANES, SAMPLE_FORMAT_SIGNED, SCRAMBLE_ENABLE}));
    $display("test reset done");
    wreg(12'h200, 8'h00);
    wreg(12'h201, 8'h3F);
    wreg(12'h202, 8'h0F);
    settle();
    chk("off", 16'h0007,
      16'({LINK_RESET, MULTIFRAME_COUNTER_RESET, SERIALIZER_POWER_DOWN}));
    chk("mode", 16'h003F, 16'(LINK_OUTPUT_MODE));
    chk("k", 16'h0010, FRAMES_PER_MULTIFRAME);
    rreg(12'h201, 8'h3F);
    @(posedge CLK);
    MODE_IS_64B66B <= 1'b1;
    MODE_E <= 8'h03;
    MODE_F <= 8'h02;
    settle();
    chk("k64", 16'h0180, FRAMES_PER_MULTIFRAME);
    @(posedge CLK);
    MODE_IS_64B66B <= 1'b0;
    CALIBRATION_ENABLE <= 1'b1;
    wreg(12'h201, 8'h05);
    #1 chk("flag", 16'h0001, 16'(MODE_WRITE_REFUSED));
    @(posedge CLK);
    CALIBRATION_ENABLE <= 1'b0;
    $display("test mode done");
    wreg(12'h203, 8'h00);
    settle();
    chk("sync", 16'h0000, 16'(SYNC_REQUEST_N));
    wreg(12'h203, 8'h01);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge CLK);
      w_ded <= pd[i];
      w_ts <= pt[i];
      wreg(12'h204, {4'h1, sel[i], 2'h0});
      settle();
      chk("sync", 16'(ex[i]), 16'(SYNC_REQUEST_N));
    end
    chk("ctl", 16'h0004, 16'({ALT_LANES, SAMPLE_FORMAT_SIGNED, SCRAMBLE_ENABLE}));
    wreg(12'h203, 8'h00);
    settle();
    chk("sync", 16'h0000, 16'(SYNC_REQUEST_N));
    $display("test sync done");
    wreg(12'h200, 8'h01);
    settle();
    chk("on", 16'h0001,
      16'({LINK_RESET, MULTIFRAME_COUNTER_RESET, SERIALIZER_POWER_DOWN, LINK_CLOCK_ENABLE}));
    $display("test relink done");
    print_verdict();
  end
endmodule : serial_link_mode_sync_regs_tb_top
